/* File: triac_pkg.sv */
// shared constants and types for the phase-angle controller
package triac_pkg;

    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int CLK_PS = 4000;
    localparam int TICK_US = 200;
    localparam logic [11:0] TICK_STEP = 12'h640;
    localparam int PRESCALE_DIV = (TICK_US * 1000 * 1000) / (32'(TICK_STEP) * CLK_PS);

    // ------------------------------------------------------------
    // mains timing, in microseconds and in ticks
    // ------------------------------------------------------------
    localparam int P50_US = 20000;
    localparam int P60_US = 16700;
    localparam int WIN_US = 1200;
    localparam int PULSE1_US = 200;
    localparam int PULSE2_US = 400;
    localparam logic [7:0] P50_TICKS = 8'(P50_US / TICK_US);
    localparam logic [7:0] P60_TICKS = 8'(P60_US / TICK_US);
    localparam logic [7:0] WIN_TICKS = 8'(WIN_US / TICK_US);
    localparam logic [1:0] PULSE1_TICKS = 2'(PULSE1_US / TICK_US);
    localparam logic [1:0] PULSE2_TICKS = 2'(PULSE2_US / TICK_US);
    localparam logic [1:0] SOFT_VAR_CYCLES = 2'h3;
    localparam logic [7:0] WDG_TIMEOUT_TICKS = 8'h80;

    // ------------------------------------------------------------
    // angle limits, adc channels, reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ANGLE_MAX = 8'h28;
    localparam logic [2:0] CH_POT = 3'h0;
    localparam logic [2:0] CH_CUR = 3'h4;
    localparam logic [1:0] PULSE_SEL_RST = 2'h2;
    localparam logic [1:0] PULSE_SEL_SHORT = 2'h1;
    localparam logic [9:0] ILIM_RST = 10'h333;
    localparam logic [7:0] SOFT_START_RST = 8'h19;

    // ------------------------------------------------------------
    // register map and field positions
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CFG = 12'h000;
    localparam logic [11:0] OFS_ILIM = 12'h004;
    localparam logic [11:0] OFS_SOFT = 12'h008;
    localparam logic [11:0] OFS_STAT = 12'h00C;
    localparam logic [11:0] OFS_ANGLE = 12'h010;
    localparam int ST_RUN = 0;
    localparam int ST_LED = 1;
    localparam int ST_LOCK = 2;
    localparam int ST_F50 = 3;
    localparam int ST_F60 = 4;
    localparam int ST_MISS = 5;
    localparam int ST_GATE = 6;

    typedef enum logic [0:0] {M_IDLE = 1'b0, M_RUN = 1'b1} mode_e;
    typedef enum logic [1:0] {Z_OFF = 2'b00, Z_SECOND = 2'b01, Z_LOCKED = 2'b10} zsync_e;

endpackage : triac_pkg

/* File: wdg_if.sv */
// link between the controller core and its watchdog
`timescale 1ns/1ps
`default_nettype none
interface wdg_if;
    logic tick;
    logic refresh;
    logic fire;
    modport core (output tick, output refresh, input fire);
    modport dog (input tick, input refresh, output fire);
endinterface : wdg_if
`default_nettype wire

/* File: triac_wdg.sv */
// landmark watchdog: expires when crossings stop being confirmed
`timescale 1ns/1ps
`default_nettype none
module triac_wdg
    import triac_pkg::*;
#(
    parameter logic [7:0] TIMEOUT = triac_pkg::WDG_TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // core link
    wdg_if.dog link
);
    typedef struct packed {
        logic armed;
        logic [7:0] cnt;
        logic fire;
    } wdg_s;

    wdg_s s_r;
    wdg_s s_nxt;

    if (TIMEOUT == 8'h00) begin : g_chk
        $error("watchdog timeout must be nonzero");
    end

    // counts ticks only, so it sleeps while the time base is stopped
    always_comb begin
        s_nxt = s_r;
        s_nxt.fire = 1'b0;
        if (link.refresh) begin
            s_nxt.armed = 1'b1;
            s_nxt.cnt = '0;
        end else if (s_r.armed && link.tick) begin
            if (s_r.cnt == TIMEOUT - 8'h01) begin
                s_nxt.fire = 1'b1;
                s_nxt.armed = 1'b0;
                s_nxt.cnt = '0;
            end else begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
        end
    end

    // only the external reset clears it; its own fire resets the core
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.fire = s_r.fire;
endmodule : triac_wdg
`default_nettype wire

/* File: triac_phase_angle_controller.sv */
// phase-angle controller core with apb registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - idle after reset, start press enters run
// - press or overcurrent returns idle, led latched
// - timers stopped until first crossing
// - crossing is falling edge of sense input
// - first crossing starts timer, compare one tick ahead
// - compare tick every 0.2 ms once synced
// - first window assumes 50 Hz mains
// - second crossing measures period, sets 50/60 flag
// - unknown period clears flags, restarts synchronisation
// - crossing valid within 1.2 ms; rearm after
// - each later crossing checked against window
// - every 3 cycles read pot, compute target
// - applied angle steps one toward target
// - missed crossing stops watchdog refresh
// - tick samples button, fires gate, counts
// - current sampled each tick while conducting
// - overcurrent forces idle, fault led on
// - compare advances by step in 12-bit counter
// - gate pulse setting 1 or 2 ticks
// - soft start holds minimum power 25 cycles
module triac_phase_angle_controller
    import triac_pkg::*;
#(
    parameter int PRESCALE = triac_pkg::PRESCALE_DIV,
    parameter logic [11:0] STEP = triac_pkg::TICK_STEP,
    parameter logic [7:0] WDG_TIMEOUT = triac_pkg::WDG_TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // mains and user pins
    input wire logic I_MAINS_SENSE_INPUT,
    input wire logic I_BUTTON_B,
    // adc
    input wire logic [9:0] I_ADC_DATA,
    output logic [2:0] O_ADC_CH,
    // outputs
    output logic O_GATE_FIRE_OUTPUT,
    output logic O_FAULT_LED,
    output logic O_WDG_RESET
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic mains_s1;
        logic mains_s2;
        logic mains_s3;
        logic btn_s1;
        logic btn_s2;
        logic btn_prev;
        mode_e mode;
        logic led;
        zsync_e zs;
        logic f50;
        logic f60;
        logic missed;
        logic [7:0] pre;
        logic [11:0] cnt;
        logic [11:0] cmp;
        logic [7:0] zc_ticks;
        logic [7:0] period;
        logic [1:0] var_cnt;
        logic [7:0] soft_cnt;
        logic [9:0] pot;
        logic [2:0] ch;
        logic [7:0] target;
        logic [7:0] angle;
        logic [1:0] gate_cnt;
        logic gate;
        logic conduct;
        logic [1:0] pulse_sel;
        logic [9:0] ilim;
        logic [7:0] soft_cfg;
        logic [31:0] prdata;
        logic pslverr;
    } core_s;

    core_s s_r;
    core_s s_nxt;
    logic strobe;
    logic tick;
    logic zc;
    logic press;
    logic refresh;
    logic [7:0] half;
    logic [11:0] waddr;

    wdg_if dog ();

    if (PRESCALE < 1 || PRESCALE > 256 || STEP == 12'h000) begin : g_chk
        $error("prescale must be 1..256 and step nonzero");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_win(input logic [7:0] t, input logic [7:0] exp);
        logic [8:0] lo;
        logic [8:0] hi;
        lo = {1'b0, t} + {1'b0, WIN_TICKS};
        hi = {1'b0, exp} + {1'b0, WIN_TICKS};
        return (lo >= {1'b0, exp}) && ({1'b0, t} <= hi);
    endfunction : in_win

    function automatic logic addr_hit(input logic [11:0] a);
        return (a == OFS_CFG) || (a == OFS_ILIM) || (a == OFS_SOFT) ||
               (a == OFS_STAT) || (a == OFS_ANGLE);
    endfunction : addr_hit

    function automatic logic [31:0] rd_mux(input core_s s, input logic [11:0] a);
        logic [31:0] d;
        d = '0;
        unique case (1'b1)
            a == OFS_CFG: d[1:0] = s.pulse_sel;
            a == OFS_ILIM: d[9:0] = s.ilim;
            a == OFS_SOFT: d[7:0] = s.soft_cfg;
            a == OFS_STAT: begin
                d[ST_RUN] = (s.mode == M_RUN);
                d[ST_LED] = s.led;
                d[ST_LOCK] = (s.zs == Z_LOCKED);
                d[ST_F50] = s.f50;
                d[ST_F60] = s.f60;
                d[ST_MISS] = s.missed;
                d[ST_GATE] = s.gate;
            end
            a == OFS_ANGLE: d[23:0] = {s.zc_ticks, s.target, s.angle};
            default: d = '0;
        endcase
        return d;
    endfunction : rd_mux

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    assign zc = s_r.mains_s3 && !s_r.mains_s2;
    assign strobe = (s_r.zs != Z_OFF) && (s_r.pre == 8'(PRESCALE - 1));
    assign tick = strobe && (s_r.cnt == s_r.cmp);
    assign press = tick && s_r.btn_prev && !s_r.btn_s2;
    assign half = {1'b0, s_r.period[7:1]};
    assign waddr = {I_PADDR[11:2], 2'b00};

    always_comb begin
        s_nxt = s_r;
        refresh = 1'b0;
        // two-flop synchronisers, third flop for edge detection
        s_nxt.mains_s1 = I_MAINS_SENSE_INPUT;
        s_nxt.mains_s2 = s_r.mains_s1;
        s_nxt.mains_s3 = s_r.mains_s2;
        s_nxt.btn_s1 = I_BUTTON_B;
        s_nxt.btn_s2 = s_r.btn_s1;

        if (s_r.zs != Z_OFF) begin
            s_nxt.pre = strobe ? 8'h00 : s_r.pre + 8'h01;
            if (strobe) begin
                s_nxt.cnt = s_r.cnt + 12'h001;
            end
        end
        if (tick) begin
            s_nxt.cmp = s_r.cmp + STEP;
        end

        // --------------------------------------------------------
        // tick work: button, adc, firing
        // --------------------------------------------------------
        if (tick) begin
            s_nxt.btn_prev = s_r.btn_s2;
            if (s_r.ch == CH_POT) begin
                s_nxt.pot = I_ADC_DATA;
            end
            if (s_r.gate_cnt != 2'h0) begin
                s_nxt.gate_cnt = s_r.gate_cnt - 2'h1;
            end
            if (s_r.zc_ticks == half) begin
                s_nxt.conduct = 1'b0;
            end
            if (s_r.mode == M_RUN && s_r.zs == Z_LOCKED &&
                (s_r.zc_ticks == s_r.angle || s_r.zc_ticks == s_r.angle + half)) begin
                s_nxt.conduct = 1'b1;
                // settings other than the short one give the long pulse
                s_nxt.gate_cnt = (s_r.pulse_sel == PULSE_SEL_SHORT) ?
                                 PULSE1_TICKS : PULSE2_TICKS;
            end
            if (s_r.mode == M_RUN && s_r.conduct && s_r.ch == CH_CUR &&
                I_ADC_DATA > s_r.ilim) begin
                s_nxt.mode = M_IDLE;
                s_nxt.led = 1'b1;
            end else if (press) begin
                if (s_r.mode == M_IDLE) begin
                    s_nxt.mode = M_RUN;
                    s_nxt.led = 1'b0;
                    s_nxt.soft_cnt = '0;
                    s_nxt.var_cnt = '0;
                    s_nxt.angle = ANGLE_MAX;
                end else begin
                    s_nxt.mode = M_IDLE;
                end
            end
        end

        // --------------------------------------------------------
        // zero-crossing synchronisation
        // --------------------------------------------------------
        unique case (s_r.zs)
            Z_OFF: begin
                if (zc) begin
                    s_nxt.zs = Z_SECOND;
                    s_nxt.cmp = s_r.cnt + STEP;
                    s_nxt.pre = '0;
                    s_nxt.zc_ticks = '0;
                    s_nxt.period = P50_TICKS;
                end
            end
            Z_SECOND: begin
                if (zc) begin
                    s_nxt.zc_ticks = '0;
                    if (in_win(s_r.zc_ticks, P50_TICKS)) begin
                        s_nxt.zs = Z_LOCKED;
                        s_nxt.f50 = 1'b1;
                        s_nxt.period = P50_TICKS;
                        refresh = 1'b1;
                    end else if (in_win(s_r.zc_ticks, P60_TICKS)) begin
                        s_nxt.zs = Z_LOCKED;
                        s_nxt.f60 = 1'b1;
                        s_nxt.period = P60_TICKS;
                        refresh = 1'b1;
                    end else begin
                        s_nxt.zs = Z_OFF;
                    end
                end else if (tick) begin
                    if (s_r.zc_ticks == P50_TICKS + WIN_TICKS) begin
                        s_nxt.zs = Z_OFF;
                    end else begin
                        s_nxt.zc_ticks = s_r.zc_ticks + 8'h01;
                    end
                end
            end
            Z_LOCKED: begin
                if (zc) begin
                    if (in_win(s_r.zc_ticks, s_r.period)) begin
                        s_nxt.zc_ticks = '0;
                        s_nxt.conduct = 1'b0;
                        refresh = !s_r.missed;
                        if (s_r.mode == M_RUN) begin
                            if (s_r.soft_cnt < s_r.soft_cfg) begin
                                s_nxt.soft_cnt = s_r.soft_cnt + 8'h01;
                                s_nxt.angle = ANGLE_MAX;
                            end else if (s_r.var_cnt == SOFT_VAR_CYCLES - 2'h1) begin
                                s_nxt.var_cnt = '0;
                                s_nxt.target = ANGLE_MAX - {3'h0, s_r.pot[9:5]};
                                if (s_r.angle < s_nxt.target) begin
                                    s_nxt.angle = s_r.angle + 8'h01;
                                end else if (s_r.angle > s_nxt.target) begin
                                    s_nxt.angle = s_r.angle - 8'h01;
                                end
                            end else begin
                                s_nxt.var_cnt = s_r.var_cnt + 2'h1;
                            end
                        end
                    end else begin
                        s_nxt.zs = Z_OFF;
                    end
                end else if (tick) begin
                    if (s_r.zc_ticks == s_r.period + WIN_TICKS) begin
                        // expected crossing gone; rearm one period on
                        s_nxt.missed = 1'b1;
                        s_nxt.zc_ticks = WIN_TICKS;
                        s_nxt.conduct = 1'b0;
                    end else begin
                        s_nxt.zc_ticks = s_r.zc_ticks + 8'h01;
                    end
                end
            end
            default: s_nxt.zs = Z_OFF;
        endcase

        // losing sync drops both frequency flags and the tick count; the missed flag stays set
        if (s_nxt.zs == Z_OFF && s_r.zs != Z_OFF) begin
            s_nxt.f50 = 1'b0;
            s_nxt.f60 = 1'b0;
            s_nxt.zc_ticks = '0;
            s_nxt.pre = '0;
            s_nxt.conduct = 1'b0;
            s_nxt.gate_cnt = '0;
        end
        if (s_nxt.mode == M_IDLE) begin
            s_nxt.conduct = 1'b0;
            s_nxt.gate_cnt = '0;
        end
        s_nxt.gate = (s_nxt.gate_cnt != 2'h0);
        if (tick) begin
            s_nxt.ch = s_nxt.conduct ? CH_CUR : CH_POT;
        end

        // --------------------------------------------------------
        // apb: decode in setup, write at the access edge
        // --------------------------------------------------------
        if (I_PSEL && !I_PENABLE) begin
            s_nxt.prdata = rd_mux(s_r, waddr);
            s_nxt.pslverr = !addr_hit(waddr);
        end
        if (I_PSEL && I_PENABLE && I_PWRITE) begin
            unique case (1'b1)
                waddr == OFS_CFG: s_nxt.pulse_sel = I_PWDATA[1:0];
                waddr == OFS_ILIM: s_nxt.ilim = I_PWDATA[9:0];
                waddr == OFS_SOFT: s_nxt.soft_cfg = I_PWDATA[7:0];
                default: s_nxt.pulse_sel = s_nxt.pulse_sel;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers; a watchdog expiry resets the core like the pin
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B || dog.fire) begin
            s_r <= '0;
            s_r.mains_s1 <= 1'b1;
            s_r.mains_s2 <= 1'b1;
            s_r.mains_s3 <= 1'b1;
            s_r.btn_s1 <= 1'b1;
            s_r.btn_s2 <= 1'b1;
            s_r.btn_prev <= 1'b1;
            s_r.period <= P50_TICKS;
            s_r.angle <= ANGLE_MAX;
            s_r.target <= ANGLE_MAX;
            s_r.pulse_sel <= PULSE_SEL_RST;
            s_r.ilim <= ILIM_RST;
            s_r.soft_cfg <= SOFT_START_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dog.tick = tick;
    assign dog.refresh = refresh;

    triac_wdg #(
        .TIMEOUT(WDG_TIMEOUT)
    ) u_wdg (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .link(dog.dog)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_PRDATA = s_r.prdata;
    assign O_PSLVERR = s_r.pslverr && I_PSEL && I_PENABLE;
    assign O_PREADY = I_PSEL && I_PENABLE;
    assign O_ADC_CH = s_r.ch;
    assign O_GATE_FIRE_OUTPUT = s_r.gate;
    assign O_FAULT_LED = s_r.led;
    assign O_WDG_RESET = dog.fire;
endmodule : triac_phase_angle_controller
`default_nettype wire

/* File: triac_phase_angle_controller_monitor.sv */
// assertion checker bound to the phase-angle controller ports
`timescale 1ns/1ps
`default_nettype none
module triac_phase_angle_controller_monitor
    import triac_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DIV,
    parameter logic [11:0] STEP = TICK_STEP
) (
    // clock, reset and bus
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [11:0] I_PADDR,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // pins
    input wire logic I_MAINS_SENSE_INPUT,
    input wire logic I_BUTTON_B,
    input wire logic [2:0] O_ADC_CH,
    input wire logic O_GATE_FIRE_OUTPUT,
    input wire logic O_FAULT_LED,
    input wire logic O_WDG_RESET
);
    localparam int TCK = int'(STEP) * PRESCALE;
    logic seen_r;
    int hi_r;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    // ----------
    // helpers: crossing seen since reset, cycles the gate stayed high
    // ----------
    always_ff @(posedge I_CLK) begin
        seen_r <= I_RST_B && !O_WDG_RESET && (seen_r || $fell(I_MAINS_SENSE_INPUT));
        hi_r <= O_GATE_FIRE_OUTPUT ? hi_r + 1 : 0;
    end
    a_pready_track: assert property (O_PREADY == (I_PSEL && I_PENABLE))
        else $error("pready not psel and penable");
    a_slverr_unmapped: assert property (
        O_PSLVERR |-> I_PSEL && I_PENABLE && I_PADDR[11:2] > 10'h004)
        else $error("stray slave error");
    a_idle_reset: assert property (
        $rose(I_RST_B) |-> !O_GATE_FIRE_OUTPUT && !O_FAULT_LED && O_ADC_CH == CH_POT)
        else $error("outputs not idle after reset");
    a_quiet_unsynced: assert property (!seen_r |-> !O_GATE_FIRE_OUTPUT && O_ADC_CH == CH_POT)
        else $error("activity before the first crossing");
    a_gate_length: assert property (hi_r <= 2 * TCK)
        else $error("gate pulse too long");
    a_gate_current: assert property ($rose(O_GATE_FIRE_OUTPUT) |-> ##[0:2] O_ADC_CH == CH_CUR)
        else $error("no current channel after firing");
    a_fault_stop: assert property (
        $rose(O_FAULT_LED) |-> $past(O_ADC_CH) == CH_CUR ##1 !O_GATE_FIRE_OUTPUT)
        else $error("bad fault stop");
    a_led_hold: assert property (
        $fell(O_FAULT_LED) && !O_WDG_RESET && !$past(O_WDG_RESET) |-> !$past(I_BUTTON_B, 3))
        else $error("led cleared without press");
    a_wdg_pulse: assert property (O_WDG_RESET |=> !O_WDG_RESET)
        else $error("watchdog pulse too long");
endmodule : triac_phase_angle_controller_monitor
bind triac_phase_angle_controller triac_phase_angle_controller_monitor #(
    .PRESCALE(PRESCALE), .STEP(STEP)) u_mon (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_MAINS_SENSE_INPUT(I_MAINS_SENSE_INPUT), .I_BUTTON_B(I_BUTTON_B), .O_ADC_CH(O_ADC_CH),
    .O_GATE_FIRE_OUTPUT(O_GATE_FIRE_OUTPUT), .O_FAULT_LED(O_FAULT_LED), .O_WDG_RESET(O_WDG_RESET)
);
`default_nettype wire

/* File: triac_mains_model.sv */
// mains sense, adc and gate model for the bench
`timescale 1ns/1ps
`default_nettype none
module triac_mains_model
    import triac_pkg::*;
(
    // stimulus
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [15:0] i_per,
    input wire logic [9:0] i_pot,
    input wire logic [9:0] i_cur,
    // device side
    input wire logic [2:0] i_ch,
    input wire logic i_gate,
    output logic o_sense,
    output logic [9:0] o_adc,
    // measurements
    output var int o_pulses,
    output var int o_width,
    output var int o_gap
);
    int cnt = 0;
    int hi = 0;
    int since = 0;
    initial begin
        o_sense = 1'b1;
        o_adc = 10'h000;
        o_pulses = 0;
        o_width = 0;
        o_gap = 0;
    end
    // idles high on its pull-up; one fall per period
    always @(posedge i_clk) begin
        cnt <= (!i_en || cnt >= int'(i_per) - 1) ? 0 : cnt + 1;
        o_sense <= !(i_en && cnt < int'(i_per) / 2);
        o_adc <= (i_ch == CH_CUR) ? i_cur : i_pot;
        hi <= i_gate ? hi + 1 : 0;
        since <= since + 1;
        if (i_gate && hi == 0) begin
            o_pulses <= o_pulses + 1;
            o_gap <= since;
            since <= 1;
        end
        if (!i_gate && hi != 0) begin
            o_width <= hi;
        end
    end
endmodule : triac_mains_model
`default_nettype wire

/* File: tb_triac_phase_angle_controller.sv */
// self-checking bench for the phase-angle controller
`timescale 1ns/1ps
`default_nettype none
module tb_triac_phase_angle_controller;
    import triac_pkg::*;
    localparam logic [11:0] T_STEP = 12'h010;
    localparam int TCK = int'(T_STEP);
    localparam int P50 = int'(P50_TICKS) * TCK;
    localparam int P60 = int'(P60_TICKS) * TCK;
    localparam int LIMIT = 95000;
    logic clk, rst_b, psel, pen, pwrite, btn_b, en, pready, pslverr, sense, gate, led, wdg, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] adc, pot, cur;
    logic [2:0] ch;
    logic [15:0] per;
    int pulses, width, gap, n, cycles, mismatches, num_checks;
    int pers[3] = '{P60, 70 * TCK, P50};
    logic [31:0] flags[3] = '{32'h14, 32'h00, 32'h0C};
    triac_phase_angle_controller #(.PRESCALE(1), .STEP(T_STEP), .WDG_TIMEOUT(8'h80)) dut (
        .I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_MAINS_SENSE_INPUT(sense), .I_BUTTON_B(btn_b),
        .I_ADC_DATA(adc), .O_ADC_CH(ch), .O_GATE_FIRE_OUTPUT(gate), .O_FAULT_LED(led),
        .O_WDG_RESET(wdg));
    triac_mains_model mains (.i_clk(clk), .i_en(en), .i_per(per), .i_pot(pot), .i_cur(cur),
        .i_ch(ch), .i_gate(gate), .o_sense(sense), .o_adc(adc), .o_pulses(pulses),
        .o_width(width), .o_gap(gap));
    // ----------
    // tasks
    // ----------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, q & m);
    endtask : rd
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // held over ticks: the button is sampled on ticks only
    task automatic press();
        btn_b <= 1'b0;
        repeat (3 * TCK) @(posedge clk);
        btn_b <= 1'b1;
        repeat (3 * TCK) @(posedge clk);
    endtask : press
    task automatic one_period();
        int p;
        @(negedge sense);
        p = pulses;
        @(negedge sense);
        n = pulses - p;
    endtask : one_period
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("[FAIL] run length expected %0d seen %0d", LIMIT - 1, cycles);
            test_done();
        end
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        {rst_b, psel, pen, pwrite, paddr, pwdata, en} = '0;
        btn_b = 1'b1;
        per = 16'(P50);
        pot = 10'h3FF;
        cur = 10'h100;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd("cfg", OFS_CFG, '1, 32'h2);
        rd("ilim", OFS_ILIM, '1, 32'h333);
        rd("soft", OFS_SOFT, '1, 32'h19);
        rd("angle", OFS_ANGLE, 32'hFFFF, 32'h2828);
        apb(1'b1, OFS_ILIM, 32'hFFFF_F200);
        apb(1'b1, OFS_STAT, 32'hFFFF_FFFF);
        apb(1'b1, OFS_SOFT, 32'h2);
        rd("ilim", OFS_ILIM, '1, 32'h200);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped", 32'h1, {q[30:0], e});
        $display("test registers done");
        press();
        rd("stat unsynced", OFS_STAT, '1, 32'h0);
        $display("test unsynced done");
        en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            per <= 16'(pers[i]);
            repeat (5 * P50) @(posedge clk);
            rd("mains flags", OFS_STAT, 32'h1C, flags[i]);
        end
        $display("test mains done");
        // lost sync lets the watchdog restore the defaults
        apb(1'b1, OFS_ILIM, 32'h200);
        apb(1'b1, OFS_SOFT, 32'h2);
        press();
        rd("run", OFS_STAT, 32'h1, 32'h1);
        rd("start angle", OFS_ANGLE, 32'hFF, 32'(ANGLE_MAX));
        one_period();
        chk("pulses", 32'h2, n);
        chk("width", 2 * TCK, width);
        chk("gap", P50 / 2, gap);
        apb(1'b1, OFS_CFG, 32'h1);
        one_period();
        one_period();
        chk("short width", TCK, width);
        repeat (8) one_period();
        apb(1'b0, OFS_ANGLE, 32'h0);
        chk("target", 32'(ANGLE_MAX - 8'(pot[9:5])), (q >> 8) & 32'hFF);
        chk("ramping", 32'h1, {31'h0, q[7:0] < ANGLE_MAX && q[7:0] > 8'h09});
        $display("test firing done");
        cur <= 10'h3FF;
        one_period();
        chk("fault led", 32'h1, {31'h0, led});
        rd("stopped", OFS_STAT, 32'h3, 32'h2);
        one_period();
        chk("no firing", 32'h0, n);
        cur <= 10'h100;
        press();
        chk("led cleared", 32'h0, {31'h0, led});
        press();
        rd("stopped by press", OFS_STAT, 32'h3, 32'h0);
        $display("test overcurrent done");
        @(negedge sense);
        @(posedge clk);
        en <= 1'b0;
        repeat (115 * TCK) @(posedge clk);
        rd("missed", OFS_STAT, 32'h20, 32'h20);
        for (n = 0; wdg !== 1'b1 && n < 200 * TCK; n++) @(posedge clk);
        chk("watchdog reset", 32'h1, {31'h0, wdg});
        repeat (2) @(posedge clk);
        rd("cfg after watchdog", OFS_CFG, '1, 32'h2);
        $display("test watchdog done");
        test_done();
    end
endmodule : tb_triac_phase_angle_controller
`default_nettype wire
